// ### inc/rxcjr_cfg.svh
`ifndef RXCJR_CFG_SVH
`define RXCJR_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define RXCJR_IDX_ERR_B0        8'h30
`define RXCJR_IDX_ERR_B1        8'h31
`define RXCJR_IDX_ERR_B2        8'h32
`define RXCJR_IDX_ERR_B3        8'h33
`define RXCJR_IDX_ERR_B4        8'h34
`define RXCJR_IDX_ERR_FLOAT     8'h35
`define RXCJR_IDX_SWING         8'h38
`define RXCJR_IDX_ACQ_GAIN      8'h4D
`define RXCJR_IDX_EQ_GAIN       8'h54
`define RXCJR_IDX_EQ_BOOST      8'h55
`define RXCJR_IDX_LOOP_FILT     8'h62
`define RXCJR_IDX_THR_INDEX     8'h6A
`define RXCJR_IDX_THR_LOW       8'h6B
`define RXCJR_IDX_THR_MID       8'h6C
`define RXCJR_IDX_THR_HIGH      8'h6D
`define RXCJR_IDX_TX_CFG2       8'h83
`define RXCJR_IDX_TX_MASK       8'h84
`define RXCJR_IDX_TX_STATUS     8'h85
`define RXCJR_IDX_CHK_CTRL      8'h86

// Reset values.
`define RXCJR_RST_SWING         8'hF5
`define RXCJR_RST_ACQ_GAIN      8'h8D
`define RXCJR_RST_EQ_GAIN       8'hA1
`define RXCJR_RST_EQ_BOOST      8'hE0
`define RXCJR_RST_LF_CTL        1'h0
`define RXCJR_RST_LF_VAL        7'h1E
`define RXCJR_RST_TX_CFG2       7'h22
`define RXCJR_RST_BYTE          8'h00

// Field positions and fixed values.
`define RXCJR_SWING_FIXED_HI    5
`define RXCJR_SWING_FIXED_LO    3
`define RXCJR_STROBE_BIT        7
`define RXCJR_THR_INDEX_VALUE   6'h04
`define RXCJR_CTRL_IRQ_ALLOW    0
`define RXCJR_CTRL_CONTINUOUS   1

`endif

// ### inc/rxcjr_pkg.sv
package rxcjr_pkg;

	// All state of the register bank, registered as one word.
	typedef struct packed {
		logic        acc;          // Second cycle of a bus access.
		logic [7:0]  rdata;        // Registered read data.
		logic [39:0] live_cnt;     // Running error total.
		logic [39:0] snap_cnt;     // Total of the last finished period.
		logic [31:0] tb_cnt;       // Position in the timebase period.
		logic [31:0] upper_latch;  // Upper bytes caught by a low-byte read.
		logic [7:0]  swing;        // Output swing level register.
		logic [7:0]  acq_gain;     // Acquisition phase gain register.
		logic [7:0]  eq_gain;      // Equalizer gain register.
		logic [7:0]  eq_boost;     // Equalizer boost register.
		logic        lf_ctl;       // Loop filter override.
		logic [6:0]  lf_val;       // Loop filter value written.
		logic        thr_strobe;   // Apply strobe awaiting service.
		logic [6:0]  thr_index;    // Index register bits 6:0.
		logic [7:0]  thr_low;      // Threshold data, first register.
		logic [7:0]  thr_mid;      // Threshold data, second register.
		logic [7:0]  thr_high;     // Threshold data, third register.
		logic [13:0] thr;          // Threshold in force.
		logic        lock_fail_irq;          // Receive lock loss.
		logic [6:0]  tx_cfg;       // Transmit config two, bits 6:0.
		logic [6:0]  mask;         // Transmit interrupt mask.
		logic [6:0]  status;       // Sticky transmit interrupt status.
		logic [1:0]  ctrl;         // Checker and interrupt control.
	} rxcjr_state_type;

endpackage

// ### src/rxcjr_regs.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rxcjr_cfg.svh"
// Operation
// - Fixed timebase shows last finished period total.
// - Continuous timebase shows live running total.
// - Low byte read catches upper four bytes.
// - Counter is forty bits over five bytes.
// - Float copy: mantissa nibble, exponent nibble.
// - Swing register middle three bits ignore writes.
// - Override selects written filter, else internal.
// - Filter readback need not equal written value.
// - Strobe applies threshold data, then self-clears.
// - Threshold bits packed across three data registers.
// - Lock loss above threshold, released below it.
// - Power-down bit zero, when set, turns transmitter off.
// - Unmasked alarm drives interrupt when globally allowed.
// - Sticky status cleared by zero write or disable.

module rxcjr_regs
	import rxcjr_pkg::*;
#(
	parameter int TIMEBASE_CYCLES = 1000  // Cycles in one fixed timebase period.
) (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Avalon-MM slave.
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Receive side.
	input  wire logic        checker_bit_error,
	input  wire logic [13:0] jitter_measure,
	input  wire logic [6:0]  acq_loop_filter_internal,
	output logic      [6:0]  acq_loop_filter_effective,
	output logic             rx_lock_loss,
	output logic      [2:0]  output_swing_select,
	output logic      [2:0]  rx_phase_det_acq_gain,
	output logic      [2:0]  eq_low_freq_gain,
	output logic      [2:0]  eq_high_freq_boost,
	output logic      [13:0] jitter_lock_loss_threshold,
	// Transmit side.
	input  wire logic [6:0]  tx_alarms,
	output logic             transmit_power_down,
	output logic             tx_irq
);

	// ****************************************************************
	// Parameter check and reset release
	// ****************************************************************

	// A one-cycle period would leave no room for the snapshot handover.
	if (TIMEBASE_CYCLES < 2) begin : g_bad_timebase
		$error("TIMEBASE_CYCLES must be at least 2");
	end

	localparam logic [31:0] TB_LAST = 32'(TIMEBASE_CYCLES - 1);  // Last cycle of a period.
	localparam logic [39:0] CNT_MAX = '1;                        // Counter saturates here.

	logic       rst_meta;  // First reset synchroniser stage.
	logic       rst_n;     // Synchronised reset used by the rest of the block.

	// Reset asserts at once and releases two edges after arst_n rises.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ****************************************************************
	// State and helper signals
	// ****************************************************************

	rxcjr_state_type s;       // Current state.
	rxcjr_state_type next_s;  // Next state.
	logic [7:0]  idx;         // Register index from the byte address.
	logic        rd_first;    // First cycle of a read.
	logic        wr_take;     // Write takes effect at this edge.
	logic [7:0]  wd;          // Write data low byte.
	logic [39:0] presented;   // Count shown to software.
	logic        err_inc;     // Counter steps this cycle.
	logic        tb_end;      // Last cycle of a fixed period.

	assign idx      = avs_address[9:2];
	assign rd_first = avs_read && !s.acc;
	assign wr_take  = avs_write && s.acc && avs_byteenable[0];
	assign wd       = avs_writedata[7:0];
	assign err_inc  = checker_bit_error && (s.live_cnt != CNT_MAX);
	assign tb_end   = !s.ctrl[`RXCJR_CTRL_CONTINUOUS] && (s.tb_cnt == TB_LAST);
	// Continuous mode shows the live total, otherwise the snapshot.
	assign presented = s.ctrl[`RXCJR_CTRL_CONTINUOUS] ? s.live_cnt : s.snap_cnt;

	// Converts a count to mantissa and exponent nibbles; lower digits are truncated.
	function automatic logic [7:0] to_float(input logic [39:0] v);
		logic [7:0] f;
		f = 8'h00;
		for (int i = 0; i < 10; i++) begin
			if (v[4*i +: 4] != 4'h0) begin
				f = {v[4*i +: 4], 4'(i + 1)};
			end
		end
		return f;
	endfunction

	// ****************************************************************
	// Next-state logic
	// ****************************************************************

	// Every access waits one cycle; read data is registered in that cycle.
	always_comb begin
		next_s = s;
		next_s.acc = (avs_read || avs_write) && !s.acc;

		// Error counting and the timebase.
		if (tb_end) begin
			next_s.snap_cnt = s.live_cnt + {39'h0, err_inc};
			next_s.live_cnt = 40'h0;
			next_s.tb_cnt   = 32'h0;
		end else begin
			next_s.live_cnt = s.live_cnt + {39'h0, err_inc};
			next_s.tb_cnt   = s.ctrl[`RXCJR_CTRL_CONTINUOUS] ? 32'h0 : s.tb_cnt + 32'h1;
		end

		// Read data mux; unmapped indices read as zero.
		if (rd_first) begin
			case (idx)
				`RXCJR_IDX_ERR_B0: begin
					next_s.rdata       = presented[7:0];
					next_s.upper_latch = presented[39:8];
				end
				`RXCJR_IDX_ERR_B1:     next_s.rdata = s.upper_latch[7:0];
				`RXCJR_IDX_ERR_B2:     next_s.rdata = s.upper_latch[15:8];
				`RXCJR_IDX_ERR_B3:     next_s.rdata = s.upper_latch[23:16];
				`RXCJR_IDX_ERR_B4:     next_s.rdata = s.upper_latch[31:24];
				`RXCJR_IDX_ERR_FLOAT:  next_s.rdata = to_float(presented);
				`RXCJR_IDX_SWING:      next_s.rdata = s.swing;
				`RXCJR_IDX_ACQ_GAIN:   next_s.rdata = s.acq_gain;
				`RXCJR_IDX_EQ_GAIN:    next_s.rdata = s.eq_gain;
				`RXCJR_IDX_EQ_BOOST:   next_s.rdata = s.eq_boost;
				// Shows the filter value in use, not the one written.
				`RXCJR_IDX_LOOP_FILT:  next_s.rdata = {s.lf_ctl, acq_loop_filter_effective};
				`RXCJR_IDX_THR_INDEX:  next_s.rdata = {s.thr_strobe, s.thr_index};
				`RXCJR_IDX_THR_LOW:    next_s.rdata = s.thr_low;
				`RXCJR_IDX_THR_MID:    next_s.rdata = s.thr_mid;
				`RXCJR_IDX_THR_HIGH:   next_s.rdata = s.thr_high;
				`RXCJR_IDX_TX_CFG2:    next_s.rdata = {1'b0, s.tx_cfg};
				`RXCJR_IDX_TX_MASK:    next_s.rdata = {1'b0, s.mask};
				`RXCJR_IDX_TX_STATUS:  next_s.rdata = {1'b0, s.status};
				`RXCJR_IDX_CHK_CTRL:   next_s.rdata = {6'h00, s.ctrl};
				default:               next_s.rdata = 8'h00;
			endcase
		end

		// A pending strobe is served one cycle after it is written.
		if (s.thr_strobe) begin
			next_s.thr_strobe = 1'b0;
			if (s.thr_index[5:0] == `RXCJR_THR_INDEX_VALUE) begin
				next_s.thr = {s.thr_high[4:0], s.thr_mid, s.thr_low[7]};
			end
		end

		// Register writes.
		if (wr_take) begin
			case (idx)
				`RXCJR_IDX_SWING: begin
					// Middle bits keep their value whatever is written.
					next_s.swing = {wd[7:6], s.swing[5:3], wd[2:0]};
				end
				`RXCJR_IDX_ACQ_GAIN:   next_s.acq_gain = wd;
				`RXCJR_IDX_EQ_GAIN:    next_s.eq_gain  = wd;
				`RXCJR_IDX_EQ_BOOST:   next_s.eq_boost = wd;
				`RXCJR_IDX_LOOP_FILT: begin
					next_s.lf_ctl = wd[7];
					next_s.lf_val = wd[6:0];
				end
				`RXCJR_IDX_THR_INDEX: begin
					next_s.thr_index  = wd[6:0];
					next_s.thr_strobe = wd[`RXCJR_STROBE_BIT];
				end
				`RXCJR_IDX_THR_LOW:    next_s.thr_low  = wd;
				`RXCJR_IDX_THR_MID:    next_s.thr_mid  = wd;
				`RXCJR_IDX_THR_HIGH:   next_s.thr_high = wd;
				`RXCJR_IDX_TX_CFG2:    next_s.tx_cfg   = wd[6:0];
				`RXCJR_IDX_TX_MASK:    next_s.mask     = wd[6:0];
				`RXCJR_IDX_CHK_CTRL:   next_s.ctrl     = wd[1:0];
				default: begin
				end
			endcase
		end

		// Lock loss holds its value while the measure equals the threshold.
		if (jitter_measure > s.thr) begin
			next_s.lock_fail_irq = 1'b1;
		end else if (jitter_measure < s.thr) begin
			next_s.lock_fail_irq = 1'b0;
		end

		// Sticky status: an alarm wins over a zero write in the same cycle.
		for (int i = 0; i < 7; i++) begin
			if (!s.ctrl[`RXCJR_CTRL_IRQ_ALLOW]) begin
				next_s.status[i] = 1'b0;
			end else if (tx_alarms[i]) begin
				next_s.status[i] = 1'b1;
			end else if (wr_take && (idx == `RXCJR_IDX_TX_STATUS) && !wd[i]) begin
				next_s.status[i] = 1'b0;
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// Count registers have no defined reset value in use; zero is chosen.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s          <= '0;
			s.swing    <= `RXCJR_RST_SWING;
			s.acq_gain <= `RXCJR_RST_ACQ_GAIN;
			s.eq_gain  <= `RXCJR_RST_EQ_GAIN;
			s.eq_boost <= `RXCJR_RST_EQ_BOOST;
			s.lf_ctl   <= `RXCJR_RST_LF_CTL;
			s.lf_val   <= `RXCJR_RST_LF_VAL;
			s.tx_cfg   <= `RXCJR_RST_TX_CFG2;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// Exactly one wait cycle per access: the first cycle registers the read data,
	// so the master sees settled data at the edge where waitrequest is low.
	// This costs a cycle per access but keeps the read mux off the output path.
	assign avs_waitrequest = (avs_read || avs_write) && !s.acc;
	assign avs_readdata    = {24'h000000, s.rdata};
	// The override picks the written value, otherwise the internal one.
	assign acq_loop_filter_effective = s.lf_ctl ? s.lf_val : acq_loop_filter_internal;
	assign rx_lock_loss               = s.lock_fail_irq;
	assign output_swing_select        = s.swing[2:0];
	assign rx_phase_det_acq_gain      = s.acq_gain[7:5];
	assign eq_low_freq_gain           = s.eq_gain[7:5];
	assign eq_high_freq_boost         = s.eq_boost[7:5];
	assign jitter_lock_loss_threshold = s.thr;
	assign transmit_power_down        = s.tx_cfg[0];
	// Mask bit zero lets the latched alarm through.
	assign tx_irq = s.ctrl[`RXCJR_CTRL_IRQ_ALLOW] && ((s.status & ~s.mask) != 7'h00);

	// ****************************************************************
	// Assertions
	// ****************************************************************

	a_swing_mid_fixed: assert property (
		@(posedge mclk) disable iff (!rst_n)
		s.swing[`RXCJR_SWING_FIXED_HI:`RXCJR_SWING_FIXED_LO] == 3'b110)
		else $error("swing middle bits changed");

	a_filter_override: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(wr_take && idx == `RXCJR_IDX_LOOP_FILT && wd[7]) |=> (acq_loop_filter_effective == $past(wd[6:0])))
		else $error("override value not applied");

	a_thresh_apply: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(wr_take && idx == `RXCJR_IDX_THR_INDEX && wd == 8'h84)
		|=> s.thr_strobe ##1 (!s.thr_strobe && s.thr == {s.thr_high[4:0], s.thr_mid, s.thr_low[7]}))
		else $error("threshold not applied by strobe");

	a_lol_assert: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(jitter_measure > jitter_lock_loss_threshold) |=> rx_lock_loss)
		else $error("lock loss not raised above threshold");

	a_lol_release: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(jitter_measure < jitter_lock_loss_threshold) |=> !rx_lock_loss)
		else $error("lock loss not released below threshold");

	a_power_down_write: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(wr_take && idx == `RXCJR_IDX_TX_CFG2) |=> (transmit_power_down == $past(wd[0])))
		else $error("power down does not follow write");

	// A status bit can only be set by its alarm, so any unmasked bit that drives
	// the interrupt must have been latched or alarming in the cycle before.
	a_irq_cause: assert property (
		@(posedge mclk) disable iff (!rst_n)
		tx_irq |-> (($past(s.status | tx_alarms) & ~s.mask) != 7'h00))
		else $error("interrupt without unmasked alarm");

	a_sticky_hold: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(s.ctrl[`RXCJR_CTRL_IRQ_ALLOW] && !(wr_take && idx == `RXCJR_IDX_TX_STATUS))
		|=> ((s.status & $past(s.status | tx_alarms)) == $past(s.status | tx_alarms)))
		else $error("sticky status lost");

	a_upper_capture: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(rd_first && idx == `RXCJR_IDX_ERR_B0) |=> (s.upper_latch == $past(presented[39:8])))
		else $error("upper bytes not caught on low byte read");

	a_snapshot_stable: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!s.ctrl[`RXCJR_CTRL_CONTINUOUS] && !tb_end) |=> $stable(s.snap_cnt))
		else $error("snapshot moved inside a period");

	a_bus_one_wait: assert property (
		@(posedge mclk) disable iff (!rst_n)
		((avs_read || avs_write) && !s.acc) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("access not answered after one wait cycle");

	// A pending strobe lives for one cycle unless software sets it again.
	a_strobe_clears: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(s.thr_strobe && !(wr_take && idx == `RXCJR_IDX_THR_INDEX && wd[`RXCJR_STROBE_BIT])) |=> !s.thr_strobe)
		else $error("threshold strobe did not clear");

	// Each fixed period starts counting from zero.
	a_live_restart: assert property (
		@(posedge mclk) disable iff (!rst_n)
		tb_end |=> (s.live_cnt == 40'h0))
		else $error("running total not restarted");

	// Below the ceiling every flagged error adds exactly one.
	a_live_step: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!tb_end && checker_bit_error && s.live_cnt != CNT_MAX) |=> (s.live_cnt == $past(s.live_cnt) + 40'h1))
		else $error("running total did not step");

	// Turning interrupts off empties the sticky status.
	a_disable_clears: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!s.ctrl[`RXCJR_CTRL_IRQ_ALLOW] |=> (s.status == 7'h00))
		else $error("status kept while disabled");

	// An equal measure neither raises nor releases lock loss.
	a_lol_hold: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(jitter_measure == jitter_lock_loss_threshold) |=> $stable(rx_lock_loss))
		else $error("lock loss moved at equal measure");

	// The level field follows every accepted write to the swing register.
	a_swing_low_write: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(wr_take && idx == `RXCJR_IDX_SWING) |=> (output_swing_select == $past(wd[2:0])))
		else $error("swing level not written");

	// A write with its low byte lane off is answered but leaves the register alone.
	a_byte_disable: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(avs_write && s.acc && !avs_byteenable[0] && idx == `RXCJR_IDX_TX_CFG2) |=> $stable(s.tx_cfg))
		else $error("write with lane off changed register");

endmodule

`default_nettype wire

// ### bench/rxcjr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host controller model on the register bus.
// ****************************************
module rxcjr_host
	import rxcjr_pkg::*;
(
	// Clock.
	input  wire logic        mclk,
	// Avalon-MM master side.
	output logic      [9:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [3:0]  avs_byteenable,
	output logic      [31:0] avs_writedata,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	// Bus idle from time zero, so reset never sees a stray request.
	initial begin
		avs_address = 10'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'h0;
		avs_writedata = 32'h0000_0000;
	end

	// One access: held until waitrequest is seen low at a rising edge.
	// Ends at a falling edge so the caller may look at settled outputs.
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic be0,
		output logic [7:0] q);
		@(posedge mclk);
		avs_address <= {idx, 2'b00};
		avs_read <= ~w;
		avs_write <= w;
		avs_byteenable <= {3'b000, be0};
		avs_writedata <= {24'h000000, d};
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge mclk);
		end
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(negedge mclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, idx, d, 1'b1, q);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [7:0] q);
		xfer(1'b0, idx, 8'h00, 1'b1, q);
	endtask

	// Start-up writes that software owes the device.
	task automatic boot;
		wr(8'h38, 8'hC2);
		wr(8'h4D, 8'h0D);
		wr(8'h54, 8'h61);
		wr(8'h55, 8'hA0);
		wr(8'h83, 8'h23);
	endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
// ****************************************
// Self-checking bench of the register bank.
// ****************************************
module tb
	import rxcjr_pkg::*;
;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        checker_bit_error = 1'b0;
	logic [13:0] jitter_measure = 14'h0000;
	logic [6:0]  acq_loop_filter_internal = 7'h55;
	logic [6:0]  tx_alarms = 7'h00;
	logic [9:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest, rx_lock_loss, transmit_power_down, tx_irq;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic [6:0]  acq_loop_filter_effective;
	logic [2:0]  output_swing_select, rx_phase_det_acq_gain, eq_low_freq_gain, eq_high_freq_boost;
	logic [13:0] jitter_lock_loss_threshold;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cycles = 0;

	always #4 mclk = ~mclk;

	// Short period keeps the fixed timebase within a few reads.
	rxcjr_regs #(.TIMEBASE_CYCLES(8)) DUT (.mclk, .arst_n, .avs_address, .avs_read, .avs_write,
		.avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .checker_bit_error,
		.jitter_measure, .acq_loop_filter_internal, .acq_loop_filter_effective, .rx_lock_loss,
		.output_swing_select, .rx_phase_det_acq_gain, .eq_low_freq_gain, .eq_high_freq_boost,
		.jitter_lock_loss_threshold, .tx_alarms, .transmit_power_down, .tx_irq);

	rxcjr_host host (.mclk, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
		.avs_readdata, .avs_waitrequest);

	task automatic end_of_test;
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// A hung handshake must not stall the run forever.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] q;
		host.rd(idx, q);
		`CHK(nm, e, q)
	endtask

	task automatic meas(input logic [13:0] v, input logic e);
		@(posedge mclk) jitter_measure <= v;
		@(posedge mclk);
		@(negedge mclk);
		`CHK("lock loss", e, rx_lock_loss)
	endtask

	task automatic errs(input int n);
		@(posedge mclk) checker_bit_error <= 1'b1;
		repeat (n) @(posedge mclk);
		checker_bit_error <= 1'b0;
	endtask

	task automatic alarm(input logic [6:0] v);
		@(posedge mclk) tx_alarms <= v;
		@(posedge mclk) tx_alarms <= 7'h00;
		@(negedge mclk);
	endtask

	task automatic t_reset;
		logic [7:0] idx [8] = '{8'h38, 8'h4D, 8'h54, 8'h55, 8'h62, 8'h83, 8'h84, 8'h10};
		logic [7:0] exp [8] = '{8'hF5, 8'h8D, 8'hA1, 8'hE0, 8'h55, 8'h22, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			rchk("reset value", idx[i], exp[i]);
		end
		`CHK("swing pins", 3'h5, output_swing_select)
		`CHK("power down", 1'b0, transmit_power_down)
	endtask

	task automatic t_boot;
		logic [7:0] q;
		host.boot();
		rchk("swing", 8'h38, 8'hF2);
		rchk("acq gain", 8'h4D, 8'h0D);
		`CHK("acq gain pins", 3'h0, rx_phase_det_acq_gain)
		`CHK("eq gain pins", 3'h3, eq_low_freq_gain)
		`CHK("eq boost pins", 3'h5, eq_high_freq_boost)
		`CHK("power down", 1'b1, transmit_power_down)
		host.xfer(1'b1, 8'h83, 8'h22, 1'b0, q);
		rchk("lane off write", 8'h83, 8'h23);
		host.wr(8'h83, 8'h22);
		`CHK("power up", 1'b0, transmit_power_down)
		host.wr(8'h88, 8'h08);
		rchk("unmapped", 8'h88, 8'h00);
	endtask

	task automatic t_thresh;
		host.wr(8'h6B, 8'hA0);
		host.wr(8'h6C, 8'h34);
		host.wr(8'h6D, 8'hA5);
		`CHK("threshold held", 14'h0000, jitter_lock_loss_threshold)
		host.wr(8'h6A, 8'h04);
		host.wr(8'h6A, 8'h84);
		@(negedge mclk);
		`CHK("threshold", 14'h0A69, jitter_lock_loss_threshold)
		rchk("strobe", 8'h6A, 8'h04);
		meas(14'h0A6A, 1'b1);
		meas(14'h0A69, 1'b1);
		host.wr(8'h62, 8'h98);
		`CHK("filter override", 7'h18, acq_loop_filter_effective)
		rchk("filter read", 8'h62, 8'h98);
		meas(14'h0A68, 1'b0);
		host.wr(8'h62, 8'h00);
		`CHK("filter internal", 7'h55, acq_loop_filter_effective)
		@(posedge mclk) acq_loop_filter_internal <= 7'h2A;
		@(negedge mclk);
		`CHK("filter follows", 7'h2A, acq_loop_filter_effective)
	endtask

	task automatic t_counter;
		host.wr(8'h86, 8'h00);
		@(posedge mclk) checker_bit_error <= 1'b1;
		repeat (16) @(posedge mclk);
		rchk("fixed total", 8'h30, 8'h08);
		for (int i = 8'h31; i <= 8'h34; i++) begin
			rchk("fixed upper", i[7:0], 8'h00);
		end
		rchk("fixed float", 8'h35, 8'h81);
		@(posedge mclk) checker_bit_error <= 1'b0;
		repeat (20) @(posedge mclk);
		rchk("quiet period", 8'h30, 8'h00);
		host.wr(8'h86, 8'h02);
		errs(300);
		rchk("live low", 8'h30, 8'h2C);
		rchk("live float", 8'h35, 8'h13);
		errs(300);
		rchk("caught byte", 8'h31, 8'h01);
		rchk("live again", 8'h30, 8'h58);
		rchk("new catch", 8'h31, 8'h02);
	endtask

	task automatic t_irq;
		host.wr(8'h86, 8'h01);
		for (int i = 0; i < 7; i++) begin
			host.wr(8'h84, ~(8'h01 << i) & 8'h7F);
			alarm(7'h01 << i);
			`CHK("unmasked alarm", 1'b1, tx_irq)
			host.wr(8'h85, ~(8'h01 << i) & 8'h7F);
			`CHK("zero write clear", 1'b0, tx_irq)
		end
		host.wr(8'h84, 8'h7F);
		alarm(7'h08);
		`CHK("masked alarm", 1'b0, tx_irq)
		rchk("sticky", 8'h85, 8'h08);
		host.wr(8'h86, 8'h00);
		rchk("disable clear", 8'h85, 8'h00);
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_boot();
		t_thresh();
		t_counter();
		t_irq();
		end_of_test();
	end
endmodule
`default_nettype wire
